/* File: rtl/dac_port_host.sv */
// Host controller driving a parallel multiplying DAC through its select, direction and data pins
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Data bus width equals DAC resolution, 8, 10 or 12 bits.
// - Write: select and direction both low while data lines hold the word.
// - Every word needs one full falling then rising select edge pair.
// - Read: direction high, select low; device drives DAC register onto bus.
module dac_port_host #(
  parameter int DATA_WIDTH = dac_port_pkg::DATA_WIDTH_DEFAULT
) (
  input  wire logic                  ref_clk_in,
  input  wire logic                  reset_in,
  input  wire logic                  write_req_in,
  input  wire logic                  read_req_in,
  input  wire logic [DATA_WIDTH-1:0] write_data_in,
  output logic                       req_ready_out,
  output logic                       write_done_out,
  output logic                       read_valid_out,
  output logic [DATA_WIDTH-1:0]      read_data_out,
  output logic [DATA_WIDTH-1:0]      shadow_code_out,
  output logic                       select_n_out,
  output logic                       dir_out,
  output logic [DATA_WIDTH-1:0]      db_out,
  output logic                       db_oe_out,
  input  wire logic [DATA_WIDTH-1:0] db_in
);
  localparam int CW = dac_port_pkg::COUNT_WIDTH;

  function automatic logic [CW-1:0] cycles(input int n);
    cycles = (n < 1) ? CW'(1) : CW'(n);
  endfunction : cycles

  dac_port_pkg::port_state_t state_reg, state_next;
  logic                  select_n_reg;
  logic                  dir_reg;
  logic [DATA_WIDTH-1:0] db_reg;
  logic                  db_oe_reg;
  logic                  ready_reg;
  logic                  write_done_reg;
  logic                  read_valid_reg;
  logic [DATA_WIDTH-1:0] read_data_reg;
  logic [DATA_WIDTH-1:0] shadow_reg;
  logic                  timer_load;
  logic [CW-1:0]         timer_count;
  logic                  timer_done;

  wire start_write = ready_reg && write_req_in;
  wire start_read  = ready_reg && read_req_in && !write_req_in;
  wire start_any   = start_write || start_read;
  wire in_setup    = (state_reg == dac_port_pkg::ST_SETUP);
  wire in_strobe   = (state_reg == dac_port_pkg::ST_STROBE);
  wire in_release  = (state_reg == dac_port_pkg::ST_RELEASE);
  wire in_gap      = (state_reg == dac_port_pkg::ST_GAP);
  wire setup_end   = in_setup && timer_done;
  wire strobe_end  = in_strobe && timer_done;
  wire gap_end     = in_gap && timer_done;
  wire is_read     = (dir_reg == dac_port_pkg::DIR_READ);

  always_comb begin
    state_next  = state_reg;
    timer_load  = 1'b0;
    timer_count = cycles(dac_port_pkg::SETUP_CYCLES);
    case (state_reg)
      dac_port_pkg::ST_IDLE: begin
        if (start_any) begin
          state_next = dac_port_pkg::ST_SETUP;
          timer_load = 1'b1;
        end
      end
      dac_port_pkg::ST_SETUP: begin
        if (timer_done) begin
          state_next  = dac_port_pkg::ST_STROBE;
          timer_load  = 1'b1;
          timer_count = cycles(dac_port_pkg::STROBE_LOW_CYCLES);
        end
      end
      dac_port_pkg::ST_STROBE: begin
        if (timer_done) begin
          state_next = dac_port_pkg::ST_RELEASE;
        end
      end
      dac_port_pkg::ST_RELEASE: begin
        state_next  = dac_port_pkg::ST_GAP;
        timer_load  = 1'b1;
        timer_count = cycles(dac_port_pkg::STROBE_HIGH_CYCLES);
      end
      dac_port_pkg::ST_GAP: begin
        if (timer_done) begin
          state_next = dac_port_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = dac_port_pkg::ST_IDLE;
      end
    endcase
  end

  phase_timer #(
    .WIDTH (CW)
  ) u_timer (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .load_in    (timer_load),
    .count_in   (timer_count),
    .done_out   (timer_done)
  );

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state_reg <= dac_port_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Next values are plain wires so that every register block below is a bare load
  logic                  select_n_next;
  logic                  dir_next;
  logic [DATA_WIDTH-1:0] db_next;
  logic                  db_oe_next;
  logic                  ready_next;
  logic                  write_done_next;
  logic                  read_valid_next;
  logic [DATA_WIDTH-1:0] read_data_next;
  logic [DATA_WIDTH-1:0] shadow_next;

  // Direction and data settle in setup, before select falls
  assign dir_next        = start_write ? dac_port_pkg::DIR_WRITE :
                           (start_read || gap_end) ? dac_port_pkg::DIR_READ :
                           dir_reg;
  assign db_next         = start_write ? write_data_in : db_reg;
  // Bus released and direction parked high after the gap so a glitch cannot write
  assign db_oe_next      = start_write ? 1'b1 : (start_read || gap_end) ? 1'b0 : db_oe_reg;
  // One falling and one rising select edge per word; data held across the rise
  assign select_n_next   = setup_end ? 1'b0 :
                           strobe_end ? dac_port_pkg::SELECT_IDLE_N :
                           select_n_reg;
  assign ready_next      = start_any ? 1'b0 : gap_end ? 1'b1 : ready_reg;
  // Sample at the end of the low phase, while the device still drives
  assign read_valid_next = strobe_end && is_read;
  assign read_data_next  = read_valid_next ? db_in : read_data_reg;
  assign write_done_next = in_release && !is_read;
  assign shadow_next     = write_done_next ? db_reg : shadow_reg;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      dir_reg <= dac_port_pkg::DIR_READ;
    end else begin
      dir_reg <= dir_next;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      db_reg <= '0;
    end else begin
      db_reg <= db_next;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      db_oe_reg <= 1'b0;
    end else begin
      db_oe_reg <= db_oe_next;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      select_n_reg <= dac_port_pkg::SELECT_IDLE_N;
    end else begin
      select_n_reg <= select_n_next;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ready_reg <= 1'b1;
    end else begin
      ready_reg <= ready_next;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      write_done_reg <= 1'b0;
    end else begin
      write_done_reg <= write_done_next;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      read_valid_reg <= 1'b0;
    end else begin
      read_valid_reg <= read_valid_next;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      read_data_reg <= '0;
    end else begin
      read_data_reg <= read_data_next;
    end
  end

  // Zero after reset stands in for the device's own power-up clear
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      shadow_reg <= '0;
    end else begin
      shadow_reg <= shadow_next;
    end
  end

  assign req_ready_out   = ready_reg;
  assign write_done_out  = write_done_reg;
  assign read_valid_out  = read_valid_reg;
  assign read_data_out   = read_data_reg;
  assign shadow_code_out = shadow_reg;
  assign select_n_out    = select_n_reg;
  assign dir_out         = dir_reg;
  assign db_out          = db_reg;
  assign db_oe_out       = db_oe_reg;
endmodule : dac_port_host
`default_nettype wire

/* File: rtl/dac_port_pkg.sv */
// Constants shared by the parallel DAC port host controller
`default_nettype none
package dac_port_pkg;
  localparam int DATA_WIDTH_DEFAULT = 12;
  // Strobe phase times in ns, and their cycle counts at the 250 MHz clock
  localparam int CLK_PERIOD_NS      = 4;
  localparam int SETUP_TIME_NS      = 8;
  localparam int STROBE_LOW_NS      = 20;
  localparam int STROBE_HIGH_NS     = 12;
  localparam int SETUP_CYCLES       = (SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_LOW_CYCLES  = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_HIGH_CYCLES = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COUNT_WIDTH        = 8;
  localparam logic SELECT_IDLE_N    = 1'b1;
  localparam logic DIR_WRITE        = 1'b0;
  localparam logic DIR_READ         = 1'b1;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_RELEASE,
    ST_GAP
  } port_state_t;
endpackage : dac_port_pkg
`default_nettype wire

/* File: rtl/phase_timer.sv */
// Down counter that times the setup, select-low and gap phases of a strobe cycle; release is one fixed cycle
`timescale 1ns/1ns
`default_nettype none
module phase_timer #(
  parameter int WIDTH = 8
) (
  input  wire logic             ref_clk_in,
  input  wire logic             reset_in,
  input  wire logic             load_in,
  input  wire logic [WIDTH-1:0] count_in,
  output logic                  done_out
);
  logic [WIDTH-1:0] count_reg;
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      count_reg <= '0;
    end else if (load_in) begin
      count_reg <= count_in;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end
  // Done on the last counted cycle so the caller moves on without a spare cycle;
  // done must not look at load_in, since the caller loads on done and would loop
  assign done_out = (count_reg <= {{(WIDTH-1){1'b0}}, 1'b1});
endmodule : phase_timer
`default_nettype wire

/* File: tb/dac_port_host_sva.sv */
// Checker for the DAC port host controller
`timescale 1ns/1ns
`default_nettype none
module dac_port_host_sva #(parameter int DATA_WIDTH = 12) (
  input wire logic                  ref_clk_in,
  input wire logic                  reset_in,
  input wire logic                  write_req_in,
  input wire logic                  read_req_in,
  input wire logic [DATA_WIDTH-1:0] write_data_in,
  input wire logic                  req_ready_out,
  input wire logic                  write_done_out,
  input wire logic                  read_valid_out,
  input wire logic [DATA_WIDTH-1:0] read_data_out,
  input wire logic [DATA_WIDTH-1:0] shadow_code_out,
  input wire logic                  select_n_out,
  input wire logic                  dir_out,
  input wire logic [DATA_WIDTH-1:0] db_out,
  input wire logic                  db_oe_out,
  input wire logic [DATA_WIDTH-1:0] db_in
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  AST_SEL_PAIR: assert property ($fell(select_n_out) |-> !select_n_out[*5] ##1 select_n_out)
    else $error("select low time wrong");
  AST_IDLE_SEL: assert property (req_ready_out |-> select_n_out)
    else $error("select low while idle");
  AST_WR_DRIVE: assert property (!select_n_out && !dir_out |-> db_oe_out)
    else $error("write without driven data");
  AST_RD_FLOAT: assert property (!select_n_out && dir_out |-> !db_oe_out)
    else $error("host drives bus in read");
  AST_WR_TAKE: assert property (req_ready_out && write_req_in |=> !dir_out && db_oe_out
    && db_out == $past(write_data_in))
    else $error("write word not set up");
  AST_WR_DONE: assert property ($rose(select_n_out) && !dir_out |=> write_done_out)
    else $error("write done missing");
  AST_SHADOW: assert property (write_done_out |-> shadow_code_out == db_out)
    else $error("shadow code wrong");
  AST_RD_DATA: assert property ($rose(select_n_out) && dir_out |-> read_valid_out
    && read_data_out == $past(db_in))
    else $error("readback wrong");
  AST_BUSY: assert property (req_ready_out && (write_req_in || read_req_in)
    |=> !req_ready_out[*8])
    else $error("ready too early");
  COV_WR: cover property (write_done_out);
  COV_RD: cover property (read_valid_out);
  COV_BOTH: cover property (req_ready_out && write_req_in && read_req_in);
endmodule : dac_port_host_sva
bind dac_port_host dac_port_host_sva #(.DATA_WIDTH(DATA_WIDTH)) chk (.*);
`default_nettype wire

/* File: tb/dac_dev_model.sv */
// Behavioural model of the parallel DAC device
`timescale 1ns/1ns
`default_nettype none
module dac_dev_model #(parameter int W = 12) (
  input wire logic         select_n_in,
  input wire logic         dir_in,
  input wire logic [W-1:0] bus_in,
  output logic [W-1:0]     dev_out
);
  logic [W-1:0] in_reg = '0;
  logic [W-1:0] dac_reg = '0;
  always @* if (!select_n_in && !dir_in) in_reg = bus_in;
  // Edge loaded only: a held select never updates the code
  always @(posedge select_n_in) if (!dir_in) dac_reg = in_reg;
  // Released bus shows the inverse so a stale value cannot pass
  assign dev_out = (!select_n_in && dir_in) ? dac_reg : ~dac_reg;
endmodule : dac_dev_model
`default_nettype wire

/* File: tb/tb.sv */
// Testbench for the DAC port host controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, a); end end
module tb;
  logic        ref_clk_in = 0;
  logic        reset_in = 1;
  logic        wr = 0, rd = 0, rdy, wdone, rvalid, sel_n, dir, oe;
  logic [11:0] wd = '0, rdata, shadow, dbo, dev, exp_code;
  wire  [11:0] bus = oe ? dbo : dev;
  int          err_total = 0, total_checks = 0;
  always #2 ref_clk_in = ~ref_clk_in;
  dac_port_host DUT (.ref_clk_in, .reset_in, .write_req_in(wr), .read_req_in(rd),
    .write_data_in(wd), .req_ready_out(rdy), .write_done_out(wdone),
    .read_valid_out(rvalid), .read_data_out(rdata), .shadow_code_out(shadow),
    .select_n_out(sel_n), .dir_out(dir), .db_out(dbo), .db_oe_out(oe), .db_in(bus));
  dac_dev_model dev_m (.select_n_in(sel_n), .dir_in(dir), .bus_in(bus), .dev_out(dev));
  task tally_and_finish;
    if (err_total == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic wait_for(input int kind);
    int n = 0;
    while (!(kind ? (wdone === 1'b1 || rvalid === 1'b1) : rdy === 1'b1) && n < 60) begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end
    if (n == 60) begin
      err_total++;
      tally_and_finish();
    end
  endtask : wait_for
  task automatic op(input logic w, input logic r, input logic [11:0] d);
    wait_for(0);
    wr = w;
    rd = r;
    wd = d;
    @(posedge ref_clk_in);
    #1;
    wr = 0;
    rd = 0;
    wait_for(1);
    if (w) begin
      exp_code = d;
      `CHK("write_done", 1'b1, wdone)
      `CHK("shadow", exp_code, shadow)
      @(posedge ref_clk_in);
      `CHK("dac_reg", exp_code, dev_m.dac_reg)
    end else begin
      `CHK("read_valid", 1'b1, rvalid)
      `CHK("readback", exp_code, rdata)
    end
  endtask : op
  initial begin
    void'($urandom(63083));
    repeat (10) @(posedge ref_clk_in);
    #1;
    reset_in = 0;
    exp_code = '0;
    `CHK("shadow_reset", exp_code, shadow)
    op(1'b0, 1'b1, '0);
    for (int i = 0; i < 24; i++) begin
      op(1'b1, 1'($urandom % 2), (i == 0) ? 12'hFFF : 12'($urandom));
      if (i % 3 != 0) op(1'b0, 1'b1, 12'($urandom));
    end
    op(1'b1, 1'b0, 12'h000);
    op(1'b0, 1'b1, 12'h000);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
